// ### logic/gcc_pkg.sv
`default_nettype none
package gcc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CARR_LO = 8'h04;
    localparam logic [7:0] OFS_CARR_HI = 8'h08;
    localparam logic [7:0] OFS_CODE_LO = 8'h0c;
    localparam logic [7:0] OFS_CODE_HI = 8'h10;
    localparam logic [7:0] OFS_SLEW = 8'h14;
    localparam logic [7:0] OFS_RST = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1c;
    localparam logic [7:0] OFS_MASK = 8'h20;
    localparam logic [7:0] OFS_RES0 = 8'h24;
    localparam logic [7:0] OFS_RES1 = 8'h28;
    localparam logic [7:0] OFS_RES2 = 8'h2c;
    localparam logic [7:0] OFS_RES3 = 8'h30;
    localparam logic [7:0] OFS_MCARR = 8'h34;
    localparam logic [7:0] OFS_MCODE = 8'h38;
    localparam logic [7:0] OFS_MEPOCH = 8'h3c;
    // Status bit positions and width
    localparam int STAT_DUMP = 0;
    localparam int STAT_MEAS = 1;
    localparam int STAT_W = 2;
    // Reset values
    localparam logic [13:0] CTRL_RESET = 14'h0000;
    localparam logic RST_RELEASE = 1'b1;
    // Code lengths and epoch counts
    localparam int GOLD_LEN = 1023;
    localparam int ML_LEN = 511;
    localparam int HALF_CHIPS = 2046;
    localparam int EPOCHS_PER_BIT = 20;
    // Measurement interval, in microseconds, and in clock cycles
    localparam int CLK_MHZ = 40;
    localparam int MEAS_SHORT_US = 9090;
    localparam int MEAS_LONG_US = 100000;
    localparam int MEAS_SHORT_CYC = MEAS_SHORT_US * CLK_MHZ;
    localparam int MEAS_LONG_CYC = MEAS_LONG_US * CLK_MHZ;
    // Dithering arm position mode
    typedef enum logic [1:0] {DITH_TRACK, DITH_EARLY, DITH_LATE} gcc_dither_e;
    // Channel control layout
    typedef struct packed {
        logic meas_long;
        gcc_dither_e dither;
        logic glonass;
        logic [1:0] spare;
        logic [7:0] code_sel;
    } gcc_ctrl_s;
    // One digitised input sample
    typedef struct packed {
        logic sign;
        logic mag;
    } gcc_sample_s;
    // Code generator output
    typedef struct packed {
        logic chip;
        logic epoch;
        logic half;
        logic [9:0] idx;
    } gcc_code_s;
endpackage
`default_nettype wire

// ### logic/gcc_code_gen.sv
`timescale 1ns/10ps
`default_nettype none
module gcc_code_gen (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Control
    input wire logic run,
    input wire logic glonass,
    input wire logic [7:0] code_sel,
    input wire logic half_tick,
    // Code output
    output var gcc_pkg::gcc_code_s code
);
    import gcc_pkg::*;

    logic [10:1] g1_r; // First Gold register
    logic [10:1] g2_r; // Second Gold register
    logic [9:1] m_r; // Maximal-length register
    logic [9:0] idx_r; // Chip index within epoch
    logic half_r; // Second half of chip
    logic epoch_r; // Epoch pulse
    logic [9:0] last_idx; // Last chip of current code
    logic gold_chip; // Gold code output

    // Pick one tap of the second register, zero if out of range
    function automatic logic tap_bit(input logic [10:1] sr, input logic [3:0] t);
        tap_bit = (t >= 4'h1 && t <= 4'ha) ? sr[t] : 1'b0;
    endfunction

    // Tap pair selects the Gold code; 33 to 37 are non-satellite codes
    assign gold_chip = g1_r[10] ^ tap_bit(g2_r, code_sel[7:4])
                     ^ tap_bit(g2_r, code_sel[3:0]);
    // Code length follows the mode
    assign last_idx = glonass ? 10'(ML_LEN - 1) : 10'(GOLD_LEN - 1);
    assign code.chip = glonass ? m_r[9] : gold_chip;
    assign code.epoch = epoch_r;
    assign code.half = half_r;
    assign code.idx = idx_r;

    // Shift registers advance once per two half-chip ticks
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            g1_r <= '1;
            g2_r <= '1;
            m_r <= '1;
            idx_r <= '0;
            half_r <= 1'b0;
            epoch_r <= 1'b0;
        end else if (!run) begin
            // Held channel restarts from the epoch state
            g1_r <= '1;
            g2_r <= '1;
            m_r <= '1;
            idx_r <= '0;
            half_r <= 1'b0;
            epoch_r <= 1'b0;
        end else begin
            epoch_r <= 1'b0;
            if (half_tick) begin
                half_r <= ~half_r;
                if (half_r) begin
                    if (idx_r == last_idx) begin
                        // Epoch end: reload so the period is exact
                        idx_r <= '0;
                        g1_r <= '1;
                        g2_r <= '1;
                        m_r <= '1;
                        epoch_r <= 1'b1;
                    end else begin
                        idx_r <= idx_r + 10'h001;
                        g1_r <= {g1_r[9:1], g1_r[3] ^ g1_r[10]};
                        g2_r <= {g2_r[9:1], g2_r[2] ^ g2_r[3] ^ g2_r[6]
                                 ^ g2_r[8] ^ g2_r[9] ^ g2_r[10]};
                        m_r <= {m_r[8:1], m_r[5] ^ m_r[9]};
                    end
                end
            end
        end
    end

    // Chip index stays inside the selected code length
    property p_idx_range;
        @(posedge hclk) disable iff (!hresetn)
        idx_r <= last_idx;
    endproperty
    a_idx_range: assert property (p_idx_range) else $error("chip index past code end");

    // Epoch pulse follows the last chip and restarts the chip index and the first Gold register
    property p_epoch_wrap;
        @(posedge hclk) disable iff (!hresetn)
        epoch_r |-> idx_r == 10'h000 && g1_r == 10'h3ff && $past(idx_r) == $past(last_idx);
    endproperty
    a_epoch_wrap: assert property (p_epoch_wrap) else $error("epoch not at code wrap");
endmodule // gcc_code_gen
`default_nettype wire

// ### logic/gcc_channel.sv
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module gcc_channel #(
    parameter int ACC_W = 20,
    parameter int unsigned MEAS_SHORT_CYC = gcc_pkg::MEAS_SHORT_CYC,
    parameter int unsigned MEAS_LONG_CYC = gcc_pkg::MEAS_LONG_CYC
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Digitised input pin
    input wire gcc_pkg::gcc_sample_s sample_in,
    // Interrupt and shared measurement instant
    output logic irq,
    output logic meas_tic
);
    import gcc_pkg::*;

    gcc_sample_s smp_s1_r; // First sync stage
    gcc_sample_s smp_s2_r; // Second sync stage
    logic acc_phase; // Address phase taken
    logic [7:0] aofs; // Decoded offset
    logic wr_en_r; // Write data phase
    logic [7:0] waddr_r; // Write offset
    logic [31:0] hrdata_r; // Read data
    gcc_ctrl_s ctrl_r; // Channel control
    logic [31:0] carr_inc_r; // Carrier increment
    logic [31:0] code_inc_r; // Code increment
    logic [10:0] slew_pend_r; // Pending half-chip slew
    logic run_r; // Channel released
    logic [STAT_W-1:0] status_r; // Sticky events
    logic [STAT_W-1:0] mask_r; // Interrupt mask
    logic [STAT_W-1:0] stat_set; // Events this cycle
    logic rd_clr; // Status read
    logic [31:0] carr_ph_r; // Carrier phase
    logic [15:0] carr_cnt_r; // Carrier cycle count
    logic [32:0] carr_sum; // Carrier sum with carry
    logic [31:0] code_ph_r; // Code oscillator phase
    logic [32:0] code_sum; // Code sum with carry
    logic half_tick; // Half-chip advance
    logic slew_go; // Slew step this cycle
    gcc_code_s code; // Code generator output
    logic [2:0] hsr_r; // Early, prompt, late chips
    logic dump_ev; // Epoch dump event
    logic [4:0] ms_cnt_r; // 1 ms epoch count
    logic [7:0] ep20_r; // 20 ms epoch count
    logic dith_phase_r; // Dithering late half
    logic dith_late; // Dither arm at late
    logic [31:0] tb_cnt_r; // Measurement timebase
    logic [31:0] tb_last; // Last timebase count
    logic tic_r; // Measurement instant
    logic [31:0] meas_carr_r; // Latched carrier data
    logic [31:0] meas_code_r; // Latched code data
    logic [31:0] meas_epoch_r; // Latched epochs
    logic signed [ACC_W-1:0] acc_r [4]; // Running sums
    logic signed [ACC_W-1:0] res_r [4]; // Dumped sums

    // Register offset, or an unmapped marker outside the window
    function automatic logic [7:0] ofs_of(input logic [31:0] a);
        ofs_of = (a[31:8] == 24'h000000) ? {a[7:2], 2'b00} : 8'hff;
    endfunction

    // Sign times magnitude times code times oscillator sign
    function automatic logic signed [2:0] mix(input gcc_sample_s s, input logic chip,
                                              input logic flip);
        logic neg;
        neg = s.sign ^ chip ^ flip;
        mix = neg ? (s.mag ? -3'sd3 : -3'sd1) : (s.mag ? 3'sd3 : 3'sd1);
    endfunction

    // Input pin passes two flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smp_s1_r <= '0;
            smp_s2_r <= '0;
        end else begin
            smp_s1_r <= sample_in;
            smp_s2_r <= smp_s1_r;
        end
    end

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign acc_phase = hsel & htrans[1] & hready;
    assign aofs = ofs_of(haddr);
    assign rd_clr = acc_phase & ~hwrite & (aofs == OFS_STAT);

    // Capture write address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_en_r <= 1'b0;
            waddr_r <= 8'hff;
        end else begin
            wr_en_r <= acc_phase & hwrite;
            if (acc_phase) begin
                waddr_r <= aofs;
            end
        end
    end

    // Software-written configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= gcc_ctrl_s'(CTRL_RESET);
            carr_inc_r <= '0;
            code_inc_r <= '0;
            run_r <= 1'b0;
            mask_r <= '0;
        end else if (wr_en_r) begin
            case (waddr_r)
                OFS_CTRL: ctrl_r <= gcc_ctrl_s'(hwdata[$bits(gcc_ctrl_s)-1:0]);
                OFS_CARR_LO: carr_inc_r[15:0] <= hwdata[15:0];
                OFS_CARR_HI: carr_inc_r[31:16] <= hwdata[15:0];
                OFS_CODE_LO: code_inc_r[15:0] <= hwdata[15:0];
                OFS_CODE_HI: code_inc_r[31:16] <= hwdata[15:0];
                OFS_RST: run_r <= (hwdata[0] == RST_RELEASE);
                OFS_MASK: mask_r <= hwdata[STAT_W-1:0];
                default: ;
            endcase
        end
    end

    // Slew write loads a half-chip count, drained one per running cycle without a code carry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slew_pend_r <= '0;
        end else if (wr_en_r && waddr_r == OFS_SLEW) begin
            slew_pend_r <= (hwdata[10:0] < 11'(HALF_CHIPS)) ? hwdata[10:0] : '0;
        end else if (slew_go) begin
            slew_pend_r <= slew_pend_r - 11'h001;
        end
    end

    // Sticky status, a set wins over the read clear
    assign dump_ev = code.epoch & run_r;
    assign stat_set = STAT_W'({tic_r, dump_ev});
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= '0;
        end else begin
            status_r <= (rd_clr ? '0 : status_r) | stat_set;
        end
    end
    assign irq = |(status_r & mask_r);

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= '0;
        end else if (acc_phase && !hwrite) begin
            case (aofs)
                OFS_CTRL: hrdata_r <= 32'(ctrl_r);
                OFS_CARR_LO: hrdata_r <= 32'(carr_inc_r[15:0]);
                OFS_CARR_HI: hrdata_r <= 32'(carr_inc_r[31:16]);
                OFS_CODE_LO: hrdata_r <= 32'(code_inc_r[15:0]);
                OFS_CODE_HI: hrdata_r <= 32'(code_inc_r[31:16]);
                OFS_SLEW: hrdata_r <= 32'(slew_pend_r);
                OFS_RST: hrdata_r <= 32'(run_r);
                OFS_STAT: hrdata_r <= 32'(status_r);
                OFS_MASK: hrdata_r <= 32'(mask_r);
                OFS_RES0: hrdata_r <= 32'(res_r[0]);
                OFS_RES1: hrdata_r <= 32'(res_r[1]);
                OFS_RES2: hrdata_r <= 32'(res_r[2]);
                OFS_RES3: hrdata_r <= 32'(res_r[3]);
                OFS_MCARR: hrdata_r <= meas_carr_r;
                OFS_MCODE: hrdata_r <= meas_code_r;
                OFS_MEPOCH: hrdata_r <= meas_epoch_r;
                default: hrdata_r <= '0;
            endcase
        end
    end

    // Carrier and code oscillators
    assign carr_sum = {1'b0, carr_ph_r} + {1'b0, carr_inc_r};
    assign code_sum = {1'b0, code_ph_r} + {1'b0, code_inc_r};
    assign slew_go = (slew_pend_r != 11'h000) & ~code_sum[32] & run_r;
    assign half_tick = code_sum[32] | slew_go;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            carr_ph_r <= '0;
            carr_cnt_r <= '0;
            code_ph_r <= '0;
        end else if (!run_r) begin
            carr_ph_r <= '0;
            carr_cnt_r <= '0;
            code_ph_r <= '0;
        end else begin
            carr_ph_r <= carr_sum[31:0];
            carr_cnt_r <= carr_cnt_r + 16'(carr_sum[32]);
            code_ph_r <= code_sum[31:0];
        end
    end

    // Code generator
    gcc_code_gen u_code (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run_r),
        .glonass(ctrl_r.glonass),
        .code_sel(ctrl_r.code_sel),
        .half_tick(half_tick & run_r),
        .code(code)
    );

    // Half-chip taps: early, prompt, late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hsr_r <= '0;
        end else if (!run_r) begin
            hsr_r <= '0;
        end else if (half_tick) begin
            hsr_r <= {hsr_r[1:0], code.chip};
        end
    end

    // Epoch counters and dither phase, stepped by own epochs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ms_cnt_r <= '0;
            ep20_r <= '0;
            dith_phase_r <= 1'b0;
        end else if (!run_r) begin
            ms_cnt_r <= '0;
            ep20_r <= '0;
            dith_phase_r <= 1'b0;
        end else if (dump_ev) begin
            if (ms_cnt_r == 5'(EPOCHS_PER_BIT - 1)) begin
                ms_cnt_r <= '0;
                ep20_r <= ep20_r + 8'h01;
                dith_phase_r <= ~dith_phase_r;
            end else begin
                ms_cnt_r <= ms_cnt_r + 5'h01;
            end
        end
    end

    // Dither arm position
    always_comb begin
        case (ctrl_r.dither)
            DITH_EARLY: dith_late = 1'b0;
            DITH_LATE: dith_late = 1'b1;
            default: dith_late = dith_phase_r;
        endcase
    end

    // Four arms: prompt I, prompt Q, dither I, dither Q
    for (genvar a = 0; a < 4; a++) begin : g_arm
        logic chip;
        logic flip;
        logic signed [2:0] prod;
        assign chip = (a < 2) ? hsr_r[1] : (dith_late ? hsr_r[2] : hsr_r[0]);
        assign flip = (a % 2 == 1) ? carr_ph_r[31] : (carr_ph_r[31] ^ carr_ph_r[30]);
        assign prod = mix(smp_s2_r, chip, flip);
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                acc_r[a] <= '0;
                res_r[a] <= '0;
            end else if (!run_r) begin
                acc_r[a] <= '0;
            end else if (dump_ev) begin
                res_r[a] <= acc_r[a];
                acc_r[a] <= ACC_W'(prod);
            end else begin
                acc_r[a] <= acc_r[a] + ACC_W'(prod);
            end
        end
    end

    // Measurement timebase, independent of channel reset
    assign tb_last = (ctrl_r.meas_long ? MEAS_LONG_CYC : MEAS_SHORT_CYC) - 1;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tb_cnt_r <= '0;
            tic_r <= 1'b0;
        end else begin
            tic_r <= (tb_cnt_r >= tb_last);
            tb_cnt_r <= (tb_cnt_r >= tb_last) ? '0 : tb_cnt_r + 32'h1;
        end
    end
    assign meas_tic = tic_r;

    // Snapshot at the common instant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meas_carr_r <= '0;
            meas_code_r <= '0;
            meas_epoch_r <= '0;
        end else if (tic_r) begin
            meas_carr_r <= {carr_cnt_r, carr_ph_r[31:16]};
            meas_code_r <= {5'h00, code.idx, code.half, code_ph_r[31:16]};
            meas_epoch_r <= {19'h0, ep20_r, ms_cnt_r};
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_dump;
        dump_ev |=> status_r[STAT_DUMP] && res_r[0] == $past(acc_r[0]);
    endproperty
    a_dump: assert property (p_dump) else $error("dump missed");

    property p_meas;
        tic_r |=> meas_epoch_r == {19'h0, $past(ep20_r), $past(ms_cnt_r)} && status_r[STAT_MEAS];
    endproperty
    a_meas: assert property (p_meas) else $error("measurement not latched");

    property p_meas_hold;
        !tic_r |=> $stable(meas_code_r) && $stable(meas_carr_r);
    endproperty
    a_meas_hold: assert property (p_meas_hold) else $error("latch off instant");

    property p_own_epoch;
        $changed(res_r[1]) |-> $past(dump_ev);
    endproperty
    a_own_epoch: assert property (p_own_epoch) else $error("dump without epoch");

    property p_carr;
        run_r && $past(run_r) |-> carr_ph_r == 32'($past(carr_ph_r) + $past(carr_inc_r));
    endproperty
    a_carr: assert property (p_carr) else $error("carrier phase step wrong");

    property p_code;
        run_r && $past(run_r) |-> code_ph_r == 32'($past(code_ph_r) + $past(code_inc_r));
    endproperty
    a_code: assert property (p_code) else $error("code phase step wrong");

    property p_held;
        !run_r |=> acc_r[0] == '0 && carr_ph_r == '0 && ms_cnt_r == '0;
    endproperty
    a_held: assert property (p_held) else $error("held channel running");

    property p_slew;
        wr_en_r && waddr_r == OFS_SLEW && hwdata[10:0] < 11'(HALF_CHIPS)
        |=> slew_pend_r == $past(hwdata[10:0]);
    endproperty
    a_slew: assert property (p_slew) else $error("slew not loaded");

    property p_dith;
        ctrl_r.dither == DITH_EARLY |-> g_arm[2].chip == hsr_r[0];
    endproperty
    a_dith: assert property (p_dith) else $error("early arm not early");

    property p_clr;
        rd_clr && !dump_ev && !tic_r |=> status_r == '0 && !irq;
    endproperty
    a_clr: assert property (p_clr) else $error("status read did not clear");
endmodule // gcc_channel
`default_nettype wire

// ### testbench/gcc_channel_bench.sv
`timescale 1ns/10ps
`default_nettype none
module gcc_channel_bench;
    import gcc_pkg::*;
    // Shortened measurement intervals in clock cycles
    localparam int unsigned SHORT_CYC = 50;
    localparam int unsigned LONG_CYC = 120;
    // Code phase step of half a chip every second clock
    localparam int HALF_CYC = 2;
    // Bus, pin and flag signals
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, meas_tic;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    gcc_sample_s sample_in = 2'b01;
    logic smp_fix = 1'b0; // Hold the input at a fixed positive level
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int t0, n;
    // Device under test, with hready looped back from the one slave
    gcc_channel #(.ACC_W(20), .MEAS_SHORT_CYC(SHORT_CYC), .MEAS_LONG_CYC(LONG_CYC)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sample_in(sample_in),
        .irq(irq), .meas_tic(meas_tic));
    // Clock at 40 MHz
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Cycle count, toggling input samples, and hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        sample_in <= smp_fix ? 2'b01 : {cyc[1], 1'b1};
        if (cyc == 80000) begin
            n_errors++;
            final_report();
        end
    end
    // Compare one value against its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One single AHB-Lite transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rr(input logic [7:0] a);
        xfer(1'b0, a, 32'h00000000);
    endtask
    // Wait for the interrupt line, or for the measurement pulse
    task automatic wait_irq();
        while (irq !== 1'b1) @(posedge hclk);
    endtask
    task automatic tic();
        @(posedge hclk);
        while (meas_tic !== 1'b1) @(posedge hclk);
    endtask
    // Cycles between two dumps; an optional slew is written after the first
    task automatic period(input int slew, output int len);
        rr(OFS_STAT);
        wait_irq();
        t0 = cyc;
        rr(OFS_STAT);
        check(rd[STAT_DUMP], 1'b1);
        rr(OFS_STAT);
        check(rd[STAT_DUMP], 1'b0);
        if (slew > 0) begin
            wr(OFS_SLEW, slew);
        end
        wait_irq();
        len = cyc - t0;
    endtask
    // Reset values, held channel, unmapped place, control read-back
    task automatic test_reset();
        rr(OFS_CTRL);
        check(rd, {18'h00000, CTRL_RESET});
        check(hresp, 1'b0);
        wr(OFS_CODE_HI, 32'h00008000);
        wr(OFS_CODE_LO, 32'h00000000);
        wr(OFS_CARR_LO, 32'h00001234);
        repeat (200) @(posedge hclk);
        rr(OFS_STAT);
        check(rd[STAT_DUMP], 1'b0);
        rr(OFS_MASK);
        check(rd, 32'h00000000);
        wr(8'h40, 32'h0000ffff);
        rr(8'h40);
        check(rd, 32'h00000000);
        wr(OFS_CTRL, 32'h00000826);
        rr(OFS_CTRL);
        check(rd, 32'h00000826);
        $display("test reset done");
    endtask
    // Dump period per code type, and code slew
    task automatic test_epoch();
        wr(OFS_MASK, 32'h00000001);
        wr(OFS_RST, {31'h00000000, RST_RELEASE});
        period(0, n);
        check(n == GOLD_LEN * 2 * HALF_CYC, 1'b1);
        period(200, n);
        check(n == (HALF_CHIPS - 200) * HALF_CYC, 1'b1);
        wr(OFS_SLEW, HALF_CHIPS);
        rr(OFS_SLEW);
        check(rd, 32'h00000000);
        wr(OFS_CTRL, 32'h00000c26);
        period(0, n);
        period(0, n);
        check(n == ML_LEN * 2 * HALF_CYC, 1'b1);
        // Half the code increment doubles every half-chip step
        wr(OFS_CODE_HI, 32'h00004000);
        period(0, n);
        check(n == ML_LEN * 4 * HALF_CYC, 1'b1);
        wr(OFS_CODE_HI, 32'h00008000);
        $display("test epoch done");
    endtask
    // Measurement instant spacing, status and masking
    task automatic test_meas();
        wr(OFS_MASK, 32'h00000000);
        rr(OFS_STAT);
        tic();
        repeat (3) @(posedge hclk);
        check(irq, 1'b0);
        wr(OFS_MASK, 32'h00000002);
        @(posedge hclk);
        check(irq, 1'b1);
        tic();
        t0 = cyc;
        tic();
        check(cyc - t0 == SHORT_CYC, 1'b1);
        wr(OFS_CTRL, 32'h00002c26);
        tic();
        t0 = cyc;
        tic();
        check(cyc - t0 == LONG_CYC, 1'b1);
        repeat (3) @(posedge hclk);
        rr(OFS_STAT);
        check(rd[STAT_MEAS], 1'b1);
        $display("test meas done");
    endtask
    // Fixed input: each full short-code epoch sums to minus twelve on every arm
    task automatic test_results();
        logic [31:0] sum;
        int got;
        sum = 32'h00000000;
        got = 0;
        wr(OFS_MASK, 32'h00000001);
        wr(OFS_CTRL, 32'h00001426);
        smp_fix <= 1'b1;
        // Let the fixed level pass the input flops before a clean epoch
        repeat (8) @(posedge hclk);
        rr(OFS_STAT);
        wait_irq();
        rr(OFS_STAT);
        // Poll at half the dump spacing, read only when flagged
        while (got < 2) begin
            repeat (ML_LEN * HALF_CYC) @(posedge hclk);
            rr(OFS_STAT);
            if (rd[STAT_DUMP] === 1'b1) begin
                rr(OFS_RES0);
                sum = sum + rd;
                rr(OFS_RES1);
                check(rd, 32'hfffffff4);
                got++;
            end
        end
        check(sum, 32'hffffffe8);
        rr(OFS_RES2);
        check(rd, 32'hfffffff4);
        $display("test results done");
    endtask
    // Counts and verdict
    task automatic final_report();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b1;
        hsize = 3'b010;
        haddr = 32'h00000000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h00000000;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset();
        test_epoch();
        test_meas();
        test_results();
        final_report();
    end
endmodule // gcc_channel_bench
`default_nettype wire
